/* File: include/tocs_pkg.sv */
package tocs_pkg;
   // ======================================================
   // widths and register map
   localparam int          CW          = 16;
   localparam int          NCH         = 4;
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_SLAVE     = 8'h04;
   localparam logic [7:0]  A_CHCFG     = 8'h08;
   localparam logic [7:0]  A_OUTCFG    = 8'h0c;
   localparam logic [7:0]  A_STATUS    = 8'h10;
   localparam logic [7:0]  A_SWEVT     = 8'h14;
   localparam logic [7:0]  A_COUNT     = 8'h18;
   localparam logic [7:0]  A_PERIOD    = 8'h1c;
   localparam logic [7:0]  A_CMP0      = 8'h20;
   localparam logic [7:0]  A_CMP3      = 8'h2c;
   // ======================================================
   // field positions
   localparam int          B_RUN       = 0;
   localparam int          B_SINGLE    = 1;
   localparam int          B_DIR       = 2;
   localparam int          B_CMODE     = 3;
   localparam int          B_TOSEL     = 5;
   localparam int          B_SYNC      = 8;
   localparam int          B_DBG       = 9;
   localparam int          B_SMODE     = 0;
   localparam int          B_TISEL     = 3;
   localparam int          B_OVERFLOW_SOURCE_SEL      = 6;
   localparam int          B_CH_EARLY  = 5;
   localparam int          B_CH_XCLR   = 6;
   localparam int          B_GEN       = 16;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [CW-1:0] PERIOD_RST = 16'hffff;
   // ======================================================
   // encodings
   localparam logic [2:0]  OM_HIGH     = 3'b001;
   localparam logic [2:0]  OM_LOW      = 3'b010;
   localparam logic [2:0]  OM_TOG      = 3'b011;
   localparam logic [2:0]  OM_F0       = 3'b100;
   localparam logic [2:0]  OM_F1       = 3'b101;
   localparam logic [2:0]  OM_PWMA     = 3'b110;
   localparam logic [2:0]  OM_PWMB     = 3'b111;
   localparam logic [2:0]  TO_SOFT     = 3'b000;
   localparam logic [2:0]  TO_RUN      = 3'b001;
   localparam logic [2:0]  TO_OVF      = 3'b010;
   localparam logic [2:0]  TO_CC       = 3'b011;
   localparam logic [1:0]  CM_ONEWAY   = 2'b00;
   localparam logic [1:0]  CM_DOWNF    = 2'b01;
   localparam logic [1:0]  CM_UPF      = 2'b10;
   localparam logic [1:0]  RESP_OK     = 2'b00;
   localparam logic [1:0]  RESP_ERR    = 2'b10;
   typedef enum logic [2:0] {
      SM_OFF  = 3'b000,
      SM_RST  = 3'b100,
      SM_SUSP = 3'b101,
      SM_TRIG = 3'b110,
      SM_EXTA = 3'b111
   } tocs_slave_e;
endpackage

/* File: src/tocs_timer_out.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Operation
// [R1] nonzero direction makes channel compare output
// [R2] period sets period, compare sets duty
// [R3] mode 110 pwm high while compare ahead
// [R4] mode 111 inverse of mode 110
// [R5] modes 100/101 hold raw at level
// [R6] 100 drives low, 101 drives high
// [R7] forced mode still raises flag and dma
// [R8] match sets, clears or toggles raw output
// [R9] single-cycle clears run at period end
// [R10] software keeps one-pulse value order legal
// [R11] early enable advances the compare decision
// [R12] polarity, enables, global enable on outputs
// [R13] trigger output chosen by 3-bit select
// [R14] external input clears raw until overflow
// [R15] clearing only in compare and pwm modes
// [R16] reset mode restarts counter, maybe overflow
// [R17] suspend mode counts while trigger high
// [R18] trigger mode rising edge starts counter
// [R19] external clock mode counts trigger pulses
// [R20] sync bit delays master start one cycle
// [R21] debug halt with hold stops counting
// [R22] count mode picks one-way or up-down flags
// [R23] one-way direction 0 up, 1 down
// [R24] single-cycle stops at update, else runs
module tocs_timer_out
   import tocs_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire logic [31:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [31:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [7:0]          trigger_input,
   input  wire logic                external_clear_input,
   input  wire logic                core_debug_halt,
   output logic                     trigger_output,
   output logic [tocs_pkg::NCH-1:0] raw_channel_output,
   output logic [tocs_pkg::NCH-1:0] main_output,
   output logic [tocs_pkg::NCH-1:0] compl_output,
   output logic [tocs_pkg::NCH-1:0] dma_request
);
   import tocs_pkg::*;

   // ======================================================
   // registers and decode
   logic [31:0]   ctrl_q, slave_q, chcfg_q, outcfg_q;
   logic [CW-1:0] cnt_q, cnt_d, period_q;
   logic [CW-1:0] cmp_q [NCH];
   logic          dir_q, trg_q, pend_q, tick_q, ovf_flag_q, soft_q;
   logic [NCH-1:0] raw_q, clr_q, ccf_q;
   logic          aw_q, w_q;
   logic [7:0]    awa_q;
   logic [31:0]   wd_q;

   tocs_slave_e   smode;
   logic          trg, trg_rise, tick, up, at_end, ovf_evt, cnt_restart, start_req, start;
   logic          wr_go, flag_end;
   logic [NCH-1:0] match;

   function automatic logic pwm_a(input logic up_c, input logic [CW-1:0] c, input logic [CW-1:0] v);
      // up: high while compare above count; down: low only while compare below count
      pwm_a = up_c ? (c > v) : !(c < v);
   endfunction

   function automatic logic out_mode_ok(input logic [2:0] m);
      out_mode_ok = (m != 3'b000) && (m != OM_F0) && (m != OM_F1);
   endfunction

   assign smode     = tocs_slave_e'(slave_q[B_SMODE +: 3]);
   assign trg       = trigger_input[slave_q[B_TISEL +: 3]];
   assign trg_rise  = trg && !trg_q;
   assign wr_go     = aw_q && w_q && !s_axi_bvalid;

   // ======================================================
   // counter gating and events
   always_comb begin
      // [R21] debug hold gate
      tick = ctrl_q[B_RUN] && !(ctrl_q[B_DBG] && core_debug_halt);
      case (smode)
         // [R17] suspend follows level
         SM_SUSP: tick = tick && trg;
         // [R19] count trigger pulses
         SM_EXTA: tick = tick && trg_rise;
         default: tick = tick;
      endcase
   end

   // [R22] [R23] direction source
   assign up          = (ctrl_q[B_CMODE +: 2] == CM_ONEWAY) ? !ctrl_q[B_DIR] : !dir_q;
   assign at_end      = up ? (cnt_q == period_q) : (cnt_q == '0);
   // [R16] reset mode restart
   assign cnt_restart = soft_q || (smode == SM_RST && trg_rise);
   assign ovf_evt     = (tick && at_end) || soft_q || (smode == SM_RST && trg_rise && !slave_q[B_OVERFLOW_SOURCE_SEL]);
   // [R18] trigger start request
   assign start_req   = (smode == SM_TRIG) && trg_rise;
   // [R20] master holds its start one cycle
   assign start       = ctrl_q[B_SYNC] ? pend_q : start_req;

   always_comb begin
      // [R22] flag qualification in up-down modes
      case (ctrl_q[B_CMODE +: 2])
         CM_ONEWAY: flag_end = 1'b1;
         CM_DOWNF:  flag_end = !up;
         CM_UPF:    flag_end = up;
         default:   flag_end = 1'b1;
      endcase
   end

   always_comb begin
      cnt_d = cnt_q;
      if (cnt_restart) begin
         cnt_d = up ? '0 : period_q;
      end else if (tick) begin
         if (!at_end) begin
            cnt_d = up ? cnt_q + 1'b1 : cnt_q - 1'b1;
         end else if (ctrl_q[B_CMODE +: 2] == CM_ONEWAY) begin
            // [R2] period register bounds the cycle
            cnt_d = up ? '0 : period_q;
         end else begin
            cnt_d = up ? cnt_q - 1'b1 : cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q  <= '0;
         dir_q  <= 1'b0;
         trg_q  <= 1'b0;
         pend_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         trg_q  <= trg;
         pend_q <= start_req;
         tick_q <= tick;
         cnt_q  <= (wr_go && awa_q == A_COUNT) ? wd_q[CW-1:0] : cnt_d;
         if (tick && at_end && ctrl_q[B_CMODE +: 2] != CM_ONEWAY) begin
            dir_q <= up;
         end
      end
   end

   // ======================================================
   // channels
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         // [R11] early mode looks at the count being loaded
         if (chcfg_q[8*i+B_CH_EARLY]) begin
            match[i] = tick && (cnt_d == cmp_q[i]);
         end else begin
            match[i] = tick_q && (cnt_q == cmp_q[i]);
         end
         // [R1] input channels never compare
         match[i] = match[i] && (chcfg_q[8*i +: 2] != 2'b00);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         raw_q <= '0;
         clr_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            // [R14] [R15] latch clear, released at overflow
            if (chcfg_q[8*i+B_CH_XCLR] && external_clear_input && out_mode_ok(chcfg_q[8*i+2 +: 3])) begin
               clr_q[i] <= 1'b1;
            end else if (ovf_evt) begin
               clr_q[i] <= 1'b0;
            end
            if (chcfg_q[8*i +: 2] == 2'b00) begin
               raw_q[i] <= 1'b0;
            end else begin
               case (chcfg_q[8*i+2 +: 3])
                  // [R8] match actions
                  OM_HIGH: raw_q[i] <= match[i] ? 1'b1 : raw_q[i];
                  OM_LOW:  raw_q[i] <= match[i] ? 1'b0 : raw_q[i];
                  OM_TOG:  raw_q[i] <= match[i] ? !raw_q[i] : raw_q[i];
                  // [R5] [R6] forced level ignores counter
                  OM_F0:   raw_q[i] <= 1'b0;
                  OM_F1:   raw_q[i] <= 1'b1;
                  // [R3] pwm a
                  OM_PWMA: raw_q[i] <= pwm_a(up, cmp_q[i], chcfg_q[8*i+B_CH_EARLY] ? cnt_d : cnt_q);
                  // [R4] pwm b inverted
                  OM_PWMB: raw_q[i] <= !pwm_a(up, cmp_q[i], chcfg_q[8*i+B_CH_EARLY] ? cnt_d : cnt_q);
                  default: raw_q[i] <= 1'b0;
               endcase
               if (clr_q[i] && out_mode_ok(chcfg_q[8*i+2 +: 3])) begin
                  raw_q[i] <= 1'b0;
               end
            end
         end
      end
   end

   // ======================================================
   // outputs, all registered
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         trigger_output     <= 1'b0;
         raw_channel_output <= '0;
         main_output        <= '0;
         compl_output       <= '0;
         dma_request        <= '0;
      end else begin
         raw_channel_output <= raw_q;
         // [R7] flag and dma follow compare in all modes
         dma_request        <= match;
         for (int i = 0; i < NCH; i++) begin
            // [R12] polarity and enable gating
            main_output[i]  <= outcfg_q[B_GEN] && outcfg_q[8+i] && (raw_q[i] ^ outcfg_q[i]);
            compl_output[i] <= outcfg_q[B_GEN] && outcfg_q[12+i] && (!raw_q[i] ^ outcfg_q[4+i]);
         end
         // [R13] trigger output select
         case (ctrl_q[B_TOSEL +: 3])
            TO_SOFT: trigger_output <= soft_q;
            TO_RUN:  trigger_output <= ctrl_q[B_RUN];
            TO_OVF:  trigger_output <= ovf_evt;
            TO_CC:   trigger_output <= |match;
            default: trigger_output <= raw_q[ctrl_q[B_TOSEL +: 2]];
         endcase
      end
   end

   // ======================================================
   // register file
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q   <= CTRL_RST;
         slave_q  <= '0;
         chcfg_q  <= '0;
         outcfg_q <= '0;
         period_q <= PERIOD_RST;
         soft_q   <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            cmp_q[i] <= '0;
         end
      end else begin
         soft_q <= wr_go && awa_q == A_SWEVT && wd_q[0];
         if (wr_go) begin
            case (awa_q)
               A_CTRL:   ctrl_q   <= wd_q & 32'h0000_03ff;
               A_SLAVE:  slave_q  <= wd_q & 32'h0000_007f;
               A_CHCFG:  chcfg_q  <= wd_q & 32'h7f7f_7f7f;
               A_OUTCFG: outcfg_q <= wd_q & 32'h0001_ffff;
               A_PERIOD: period_q <= wd_q[CW-1:0];
               default: begin
                  // unaligned offsets answer an error, so they must not land
                  if (awa_q >= A_CMP0 && awa_q <= A_CMP3 && awa_q[1:0] == 2'b00) begin
                     cmp_q[awa_q[3:2]] <= wd_q[CW-1:0];
                  end
               end
            endcase
         end
         // [R9] [R24] one pulse: run cleared at update
         if (ctrl_q[B_SINGLE] && tick && at_end) begin
            ctrl_q[B_RUN] <= 1'b0;
         end
         // [R18] hardware start wins over any clear
         if (start) begin
            ctrl_q[B_RUN] <= 1'b1;
         end
      end
   end

   // sticky flags; a set in the clearing cycle survives
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ovf_flag_q <= 1'b0;
         ccf_q      <= '0;
      end else begin
         if (wr_go && awa_q == A_STATUS) begin
            ovf_flag_q <= ovf_flag_q && !wd_q[0];
            ccf_q      <= ccf_q & ~wd_q[4:1];
         end
         if (ovf_evt && flag_end) begin
            ovf_flag_q <= 1'b1;
         end
         // [R7] flags set regardless of forced level
         ccf_q <= ((wr_go && awa_q == A_STATUS) ? (ccf_q & ~wd_q[4:1]) : ccf_q) | match;
      end
   end

   // ======================================================
   // axi4-lite slave, one write and one read at a time
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_q          <= 1'b0;
         w_q           <= 1'b0;
         awa_q         <= '0;
         wd_q          <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q          <= 1'b1;
            awa_q         <= s_axi_awaddr[7:0];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q          <= 1'b1;
            // partial strobes merge only the enabled lanes into zero
            for (int b = 0; b < 4; b++) begin
               wd_q[8*b +: 8] <= s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8] : 8'h00;
            end
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awa_q > A_CMP3 || awa_q[1:0] != 2'b00) ? RESP_ERR : RESP_OK;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_q          <= 1'b0;
            w_q           <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OK;
         case (s_axi_araddr[7:0])
            A_CTRL:   s_axi_rdata <= ctrl_q;
            A_SLAVE:  s_axi_rdata <= slave_q;
            A_CHCFG:  s_axi_rdata <= chcfg_q;
            A_OUTCFG: s_axi_rdata <= outcfg_q;
            A_STATUS: s_axi_rdata <= {22'h0, dir_q, raw_q, ccf_q, ovf_flag_q};
            A_SWEVT:  s_axi_rdata <= 32'h0;
            A_COUNT:  s_axi_rdata <= {16'h0, cnt_q};
            A_PERIOD: s_axi_rdata <= {16'h0, period_q};
            A_CMP0, 8'h24, 8'h28, A_CMP3: s_axi_rdata <= {16'h0, cmp_q[s_axi_araddr[3:2]]};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_ERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   pwm_a_level_a: assert property (!dir_q && ctrl_q[B_CMODE +: 2] == CM_ONEWAY && !ctrl_q[B_DIR]
      && chcfg_q[1:0] != 2'b00 && chcfg_q[4:2] == OM_PWMA && !chcfg_q[B_CH_EARLY] && !clr_q[0]
      && $stable(chcfg_q) ##0 $stable(cmp_q[0]) |=> raw_q[0] == $past(cmp_q[0] > cnt_q))  // [R3]
      else $error("pwm a level wrong");
   forced_level_a: assert property (chcfg_q[1:0] != 2'b00 && chcfg_q[4:2] == OM_F1 |=> raw_q[0])  // [R6]
      else $error("forced high not high");
   toggle_match_a: assert property (chcfg_q[1:0] != 2'b00 && chcfg_q[4:2] == OM_TOG && match[0]
      && !clr_q[0] |=> raw_q[0] != $past(raw_q[0]))  // [R8]
      else $error("toggle missed");
   one_pulse_a: assert property (ctrl_q[B_SINGLE] && tick && at_end && !start && !wr_go
      |=> !ctrl_q[B_RUN])  // [R9]
      else $error("run not cleared");
   ext_clear_a: assert property (clr_q[0] && out_mode_ok(chcfg_q[4:2]) && chcfg_q[1:0] != 2'b00
      |=> !raw_q[0])  // [R14]
      else $error("clear not applied");
   trig_ovf_a: assert property (ctrl_q[B_TOSEL +: 3] == TO_OVF && ovf_evt |=> trigger_output)  // [R13]
      else $error("overflow trigger lost");
   suspend_hold_a: assert property (smode == SM_SUSP && !trg && !cnt_restart && !wr_go
      |=> $stable(cnt_q))  // [R17]
      else $error("counted while suspended");
   debug_hold_a: assert property (ctrl_q[B_DBG] && core_debug_halt && !cnt_restart && !wr_go
      |=> $stable(cnt_q))  // [R21]
      else $error("counted in debug halt");
   sync_start_a: assert property (ctrl_q[B_SYNC] && start_req && !ctrl_q[B_RUN] && $stable(ctrl_q)
      |=> ##1 ctrl_q[B_RUN])  // [R20]
      else $error("sync start missing");
endmodule

/* File: dv/tocs_peer_timer.sv */
`timescale 1ns/1ps
module tocs_peer_timer #(
   parameter int GAP = 4
) (
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic run,
   output logic      ovf_pulse
);
   logic [7:0] cnt_q;
   // ======================================================
   // master period counter
   // restarts from zero whenever run drops, so bursts are exact
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         cnt_q <= 8'h00;
      else if (!run || cnt_q == 8'(GAP - 1))
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
   end
   // overflow pulse out
   // one cycle wide, low outside run, so each wrap is one rising edge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         ovf_pulse <= 1'b0;
      else
         ovf_pulse <= run && cnt_q == 8'(GAP - 1);
   end
endmodule

/* File: dv/timer_output_compare_sync_bench.sv */
`timescale 1ns/1ps
module timer_output_compare_sync_bench;
   import tocs_pkg::*;
   logic        clock, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, ext_clr, halt, trig_out, peer_run, peer_ovf;
   logic [31:0] awaddr, wdata, araddr, rdata, rd;
   logic [3:0]  wstrb, raw, mo, co, dma;
   logic [1:0]  bresp, rresp, rs;
   int          n_errors, compares, cycles, pulses, mhi, dm, th, ch;
   int          hi [4];
   int          tg [4];
   // ======================================================
   // design and far-side timer
   tocs_timer_out dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trigger_input({7'h00, peer_ovf}), .external_clear_input(ext_clr), .core_debug_halt(halt),
      .trigger_output(trig_out), .raw_channel_output(raw), .main_output(mo), .compl_output(co),
      .dma_request(dma));
   tocs_peer_timer #(.GAP(4)) peer (.clock(clock), .arst_n(arst_n), .run(peer_run), .ovf_pulse(peer_ovf));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      pulses += int'(peer_ovf);
      cycles++;
      // a hang here is counted as a mismatch
      if (cycles == 5000) begin
         n_errors++;
         summarize();
      end
   end
   // ======================================================
   // shared tasks
   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clock);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic smp(input int n);
      logic [3:0] p;
      mhi = 0;
      dm = 0;
      th = 0;
      ch = 0;
      for (int i = 0; i < 4; i++) begin
         hi[i] = 0;
         tg[i] = 0;
      end
      @(posedge clock);
      p = raw;
      repeat (n) begin
         @(posedge clock);
         for (int i = 0; i < 4; i++) begin
            hi[i] += int'(raw[i]);
            tg[i] += int'(raw[i] !== p[i]);
         end
         mhi += int'(mo[0]);
         dm += int'(dma[2]);
         th += int'(trig_out);
         ch += int'(co[0]);
         p = raw;
      end
   endtask
   function automatic logic [7:0] cb(input logic [2:0] m);
      return {3'b000, m, 2'b01};
   endfunction
   task automatic tsel(input logic [2:0] s, input logic e);
      wr(A_CTRL, 32'h1 | (32'(s) << B_TOSEL));
      repeat (3) @(posedge clock);
      chk({31'h0, trig_out}, {31'h0, e});
   endtask
   // ======================================================
   // scenarios
   task automatic t_pwm();
      rdr(A_PERIOD);
      chk(rd, {16'h0, PERIOD_RST});
      rdr(8'h40);
      chk({30'h0, rs}, {30'h0, RESP_ERR});
      wr(A_PERIOD, 32'h9);
      wr(A_CMP0, 32'h4);
      wr(A_CMP0 + 8'h4, 32'h4);
      wr(A_CMP0 + 8'h8, 32'h4);
      wr(A_CHCFG, {cb(OM_F0), cb(OM_F1), cb(OM_PWMB), cb(OM_PWMA)});
      wr(A_OUTCFG, 32'h0001_ff00);
      wr(A_CTRL, 32'h1);
      repeat (12) @(posedge clock);
      smp(20);
      chk(32'(hi[0]), 32'h8);
      chk(32'(hi[1]), 32'hc);
      chk(32'(hi[2]), 32'h14);
      chk(32'(hi[3]), 32'h0);
      chk(32'(mhi), 32'h8);
      chk(32'(ch), 32'hc);
      chk(32'(dm), 32'h2);
      tsel(TO_RUN, 1'b1);
      tsel(3'b110, 1'b1);
      tsel(3'b111, 1'b0);
      wr(A_CTRL, 32'h1 | (32'(TO_OVF) << B_TOSEL));
      smp(20);
      chk(32'(th), 32'h2);
      $display("test pwm done");
   endtask
   task automatic t_cmp();
      wr(A_CHCFG, {cb(OM_F1), cb(OM_LOW), cb(OM_HIGH), cb(OM_TOG)});
      repeat (12) @(posedge clock);
      smp(20);
      chk(32'(tg[0]), 32'h2);
      chk(32'(hi[1]), 32'h14);
      chk(32'(hi[2]), 32'h0);
      $display("test compare done");
   endtask
   task automatic t_clr();
      wr(A_CHCFG, {cb(OM_F0), cb(OM_F1) | 8'h40, cb(OM_PWMA), cb(OM_PWMA) | 8'h40});
      ext_clr <= 1'b1;
      repeat (12) @(posedge clock);
      smp(20);
      chk(32'(hi[0]), 32'h0);
      chk(32'(hi[1]), 32'h8);
      chk(32'(hi[2]), 32'h14);
      ext_clr <= 1'b0;
      repeat (22) @(posedge clock);
      smp(20);
      chk(32'(hi[0]), 32'h8);
      $display("test clear done");
   endtask
   task automatic t_hold();
      logic [31:0] a;
      wr(A_CTRL, 32'h1 | (32'h1 << B_DBG));
      halt <= 1'b1;
      rdr(A_COUNT);
      a = rd;
      repeat (6) @(posedge clock);
      rdr(A_COUNT);
      chk(rd, a);
      halt <= 1'b0;
      wr(A_CTRL, 32'h0);
      wr(A_COUNT, 32'h0);
      // counter below compare, compare not above period
      wr(A_CTRL, 32'h3);
      repeat (30) @(posedge clock);
      rdr(A_CTRL);
      chk({31'h0, rd[B_RUN]}, 32'h0);
      $display("test hold and single done");
   endtask
   task automatic t_slave();
      int p0;
      wr(A_PERIOD, 32'hffff);
      wr(A_COUNT, 32'h0);
      wr(A_SLAVE, {29'h0, SM_EXTA});
      wr(A_CTRL, 32'h1);
      p0 = pulses;
      peer_run <= 1'b1;
      repeat (40) @(posedge clock);
      peer_run <= 1'b0;
      repeat (4) @(posedge clock);
      rdr(A_COUNT);
      chk(rd, 32'(pulses - p0));
      wr(A_CTRL, 32'h0);
      wr(A_SLAVE, {29'h0, SM_TRIG});
      rdr(A_CTRL);
      chk({31'h0, rd[B_RUN]}, 32'h0);
      peer_run <= 1'b1;
      repeat (8) @(posedge clock);
      peer_run <= 1'b0;
      rdr(A_CTRL);
      chk({31'h0, rd[B_RUN]}, 32'h1);
      $display("test slave done");
   endtask
   task automatic t_more();
      wr(A_SLAVE, 32'h0);
      wr(A_PERIOD, 32'h9);
      wr(A_CHCFG, {24'h0, cb(OM_PWMA)});
      wr(A_COUNT, 32'h0);
      wr(A_CTRL, 32'h1 | (32'h1 << B_DIR));
      repeat (12) @(posedge clock);
      smp(20);
      chk(32'(hi[0]), 32'ha);
      wr(A_CTRL, 32'h1);
      wr(A_PERIOD, 32'hffff);
      wr(A_SLAVE, {29'h0, SM_RST});
      peer_run <= 1'b1;
      repeat (20) @(posedge clock);
      rdr(A_COUNT);
      // each master pulse restarts the count, so it never climbs past 3
      chk({31'h0, rd < 32'h5}, 32'h1);
      peer_run <= 1'b0;
      $display("test down and reset done");
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, ext_clr, halt, peer_run} = 8'h00;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hf;
      arst_n = 1'b0;
      n_errors = 0;
      compares = 0;
      cycles = 0;
      pulses = 0;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      t_pwm();
      t_cmp();
      t_clr();
      t_hold();
      t_slave();
      t_more();
      summarize();
   end
endmodule
